// ==== inc/aod_pkg.sv ====
//////////////////////////////////////////////////////////////////////////////
// Purpose: Shared constants for the audio output sample fetch block.
// Assumes: Register offsets are byte addresses on the plain register port.
// Notes:   Field positions here must match the read-back packing in the
//          main module.
//////////////////////////////////////////////////////////////////////////////
package aod_pkg;

    // Register byte offsets.
    localparam logic [7:0] AOD_OFS_CTL    = 8'h00;
    localparam logic [7:0] AOD_OFS_STATUS = 8'h04;
    localparam logic [7:0] AOD_OFS_FIRST_BUFFER_BASE  = 8'h08;
    localparam logic [7:0] AOD_OFS_SECOND_BUFFER_BASE  = 8'h0C;
    localparam logic [7:0] AOD_OFS_SIZE   = 8'h10;
    localparam logic [7:0] AOD_OFS_TSTAMP = 8'h14;

    // Control register field positions.
    localparam int AOD_CTL_TX_ON    = 0;
    localparam int AOD_CTL_LITTLE   = 1;
    localparam int AOD_CTL_INVERT   = 2;
    localparam int AOD_CTL_FMT_LO   = 3;
    localparam int AOD_CTL_LANES_LO = 5;
    localparam int AOD_CTL_IRQ1_ON  = 7;
    localparam int AOD_CTL_IRQ2_ON  = 8;
    localparam int AOD_CTL_FIRST_BUFFER_ACKNOWLEDGE     = 9;
    localparam int AOD_CTL_ACK2     = 10;
    localparam int AOD_CTL_SOFT_RST = 31;

    // Status register field positions.
    localparam int AOD_ST_CUR1 = 0;
    localparam int AOD_ST_DRN1 = 1;
    localparam int AOD_ST_DRN2 = 2;

    // Values after reset.
    localparam logic [31:0] AOD_BASE_RST  = 32'h0;
    localparam logic [31:0] AOD_SIZE_RST  = 32'h0;
    localparam logic [1:0]  AOD_LANES_RST = 2'h0;

    // Byte steps between consecutive samples.
    localparam logic [31:0] AOD_STEP16 = 32'h2;
    localparam logic [31:0] AOD_STEP32 = 32'h4;

    // Most significant bit masks.
    localparam logic [31:0] AOD_MSB16 = 32'h0000_8000;
    localparam logic [31:0] AOD_MSB32 = 32'h8000_0000;

    typedef enum logic [1:0]
    {
        AOD_FMT_M32 = 2'h0,
        AOD_FMT_S32 = 2'h1,
        AOD_FMT_M16 = 2'h2,
        AOD_FMT_S16 = 2'h3
    } aod_fmt_e;

    typedef enum logic [1:0]
    {
        AOD_ST_IDLE  = 2'h0,
        AOD_ST_FETCH = 2'h1,
        AOD_ST_FULL  = 2'h3
    } aod_state_e;

endpackage

// ==== core/aod_sample_fmt.sv ====
//////////////////////////////////////////////////////////////////////////////
// Purpose: Byte order selection and MSB inversion of one sample word.
// Assumes: Byte k of i_word is the memory byte at word address plus k.
// Notes:   A zero word through this path gives the idle-lane fill value.
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ns
module aod_sample_fmt
    import aod_pkg::*;
(
    // Raw memory word and selection.
    input  wire logic [31:0] i_word,
    input  wire logic        i_half_hi,
    input  wire logic        i_is16,
    // Controls.
    input  wire logic        i_little,
    input  wire logic        i_invert,
    // Result, 16-bit samples sit in the low half.
    output logic      [31:0] o_sample
);

    wire [7:0]  first_byte;
    wire [7:0]  second_byte;
    wire [15:0] s16;
    wire [31:0] s32;
    wire [31:0] raw;
    wire [31:0] msb_mask;

    assign first_byte  = i_half_hi ? i_word[23:16] : i_word[7:0];
    assign second_byte = i_half_hi ? i_word[31:24] : i_word[15:8];

    assign s16 = i_little ? {second_byte, first_byte}
                          : {first_byte, second_byte};
    assign s32 = i_little ? i_word
                          : {i_word[7:0], i_word[15:8],
                             i_word[23:16], i_word[31:24]};

    assign raw      = i_is16 ? {16'h0, s16} : s32;
    assign msb_mask = i_is16 ? AOD_MSB16 : AOD_MSB32;

    assign o_sample = i_invert ? (raw ^ msb_mask) : raw;

endmodule

// ==== core/aod_dma.sv ====
//////////////////////////////////////////////////////////////////////////////
// Purpose: Double-buffer sample fetch DMA feeding up to four output lanes.
// Assumes: One memory read outstanding at a time; i_mem_ack returns data.
// Notes:   A whole frame of samples is staged ahead; a request before it is complete gets the idle fill.
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ns
module aod_dma
    import aod_pkg::*;
#(
    parameter int NUM_LANES = 4
)
(
    // Clock and chip reset.
    input  wire logic                   i_core_clk,
    input  wire logic                   i_rst_n,
    // Processor core reset pulse.
    input  wire logic                   i_core_reset,
    // Register port.
    input  wire logic [7:0]             i_addr,
    input  wire logic [31:0]            i_wr_data,
    input  wire logic                   i_wr,
    input  wire logic                   i_rd,
    output logic      [31:0]            o_rd_data,
    // Memory read port.
    output logic                        o_mem_req,
    output logic      [31:0]            o_mem_addr,
    input  wire logic                   i_mem_ack,
    input  wire logic [31:0]            i_mem_rdata,
    // Serializer side.
    input  wire logic                   i_frame_req,
    output logic      [NUM_LANES*32-1:0] o_left_data,
    output logic      [NUM_LANES*32-1:0] o_right_data,
    output logic                        o_frame_filled,
    output logic                        o_transmit_on,
    // Interrupt request, source 12.
    output logic                        o_irq
);

    //////////////////////////////////////////////////////////////////////////
    // Register port decode.

    wire wr_ctl;
    wire soft_rst;
    wire unit_rst;
    wire ts_rst;
    wire first_buffer_acknowledge;
    wire ack2;

    assign wr_ctl   = i_wr && (i_addr == AOD_OFS_CTL);
    assign soft_rst = wr_ctl && i_wr_data[AOD_CTL_SOFT_RST];
    assign unit_rst = !i_rst_n || soft_rst;
    assign ts_rst   = !i_rst_n || i_core_reset;
    assign first_buffer_acknowledge     = wr_ctl && i_wr_data[AOD_CTL_FIRST_BUFFER_ACKNOWLEDGE];
    assign ack2     = wr_ctl && i_wr_data[AOD_CTL_ACK2];

    logic        transmit_on;
    logic        little;
    logic        invert;
    logic [1:0]  fmt;
    logic [1:0]  lanes;
    logic        irq1_on;
    logic        irq2_on;
    logic [31:0] first_buffer_base;
    logic [31:0] second_buffer_base;
    logic [31:0] size;

    always_ff @(posedge i_core_clk)
    begin
        if (unit_rst)
        begin
            transmit_on <= 1'b0;
            little      <= 1'b0;
            invert      <= 1'b0;
            fmt         <= AOD_FMT_M32;
            lanes       <= AOD_LANES_RST;
            irq1_on     <= 1'b0;
            irq2_on     <= 1'b0;
        end
        else if (wr_ctl)
        begin
            transmit_on <= i_wr_data[AOD_CTL_TX_ON];
            little      <= i_wr_data[AOD_CTL_LITTLE];
            invert      <= i_wr_data[AOD_CTL_INVERT];
            fmt         <= i_wr_data[AOD_CTL_FMT_LO +: 2];
            lanes       <= i_wr_data[AOD_CTL_LANES_LO +: 2];
            irq1_on     <= i_wr_data[AOD_CTL_IRQ1_ON];
            irq2_on     <= i_wr_data[AOD_CTL_IRQ2_ON];
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (unit_rst)
        begin
            first_buffer_base <= AOD_BASE_RST;
            second_buffer_base <= AOD_BASE_RST;
            size  <= AOD_SIZE_RST;
        end
        else if (i_wr)
        begin
            if (i_addr == AOD_OFS_FIRST_BUFFER_BASE)
                first_buffer_base <= i_wr_data;
            if (i_addr == AOD_OFS_SECOND_BUFFER_BASE)
                second_buffer_base <= i_wr_data;
            if (i_addr == AOD_OFS_SIZE)
                size <= i_wr_data;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Fetch sequencing.

    aod_state_e  state;
    aod_state_e  next_state;
    logic [2:0]  slot;
    logic [31:0] offset;
    logic [31:0] units;
    logic        first_current;
    logic        drained1;
    logic        drained2;

    wire         is16;
    wire         stereo;
    wire [31:0]  step;
    wire [2:0]   last_slot;
    wire [1:0]   slot_lane;
    wire         slot_right;
    wire [31:0]  cur_addr;
    wire         fetch_done;
    wire         unit_done;
    wire         buf_end;
    wire         frame_take;

    assign is16       = fmt[1];
    assign stereo     = fmt[0];
    assign step       = is16 ? AOD_STEP16 : AOD_STEP32;
    assign last_slot  = stereo ? {lanes, 1'b1} : {1'b0, lanes};
    assign slot_lane  = stereo ? slot[2:1] : slot[1:0];
    assign slot_right = stereo && slot[0];
    assign cur_addr   = (first_current ? first_buffer_base : second_buffer_base) + offset;
    assign fetch_done = (state == AOD_ST_FETCH) && i_mem_ack;
    assign unit_done  = fetch_done && (!stereo || slot_right);
    assign buf_end    = unit_done && ((units + 32'h1) == size);
    assign frame_take = (state == AOD_ST_FULL) && i_frame_req;

    assign o_mem_req     = (state == AOD_ST_FETCH);
    assign o_mem_addr    = {cur_addr[31:2], 2'b00};
    assign o_transmit_on = transmit_on;

    always_comb
    begin
        case (state)
            AOD_ST_IDLE:
                next_state = transmit_on ? AOD_ST_FETCH : AOD_ST_IDLE;
            AOD_ST_FETCH:
                next_state = (fetch_done && slot == last_slot)
                           ? AOD_ST_FULL : AOD_ST_FETCH;
            AOD_ST_FULL:
                if (i_frame_req)
                    next_state = transmit_on ? AOD_ST_FETCH : AOD_ST_IDLE;
                else
                    next_state = AOD_ST_FULL;
            default:
                next_state = AOD_ST_IDLE;
        endcase
    end

    always_ff @(posedge i_core_clk)
    begin
        if (unit_rst)
            state <= AOD_ST_IDLE;
        else
            state <= next_state;
    end

    always_ff @(posedge i_core_clk)
    begin
        if (unit_rst || state != AOD_ST_FETCH)
            slot <= 3'h0;
        else if (fetch_done)
            slot <= (slot == last_slot) ? 3'h0 : slot + 3'h1;
    end

    always_ff @(posedge i_core_clk)
    begin
        if (unit_rst)
        begin
            offset        <= 32'h0;
            units         <= 32'h0;
            first_current <= 1'b1;
        end
        else if (buf_end)
        begin
            offset        <= 32'h0;
            units         <= 32'h0;
            first_current <= !first_current;
        end
        else if (fetch_done)
        begin
            offset <= offset + step;
            if (unit_done)
                units <= units + 32'h1;
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (unit_rst)
        begin
            drained1 <= 1'b0;
            drained2 <= 1'b0;
        end
        else
        begin
            drained1 <= (buf_end && first_current) || (drained1 && !first_buffer_acknowledge);
            drained2 <= (buf_end && !first_current) || (drained2 && !ack2);
        end
    end

    // level request while flag and enable
    assign o_irq = (drained1 && irq1_on) || (drained2 && irq2_on);

    //////////////////////////////////////////////////////////////////////////
    // Sample formatting and frame staging.

    logic [31:0] sample;
    logic [31:0] zero_fill;

    aod_sample_fmt u_fmt_data
    (
        .i_word    (i_mem_rdata),
        .i_half_hi (cur_addr[1]),
        .i_is16    (is16),
        .i_little  (little),
        .i_invert  (invert),
        .o_sample  (sample)
    );

    aod_sample_fmt u_fmt_zero
    (
        .i_word    (32'h0),
        .i_half_hi (1'b0),
        .i_is16    (is16),
        .i_little  (little),
        .i_invert  (invert),
        .o_sample  (zero_fill)
    );

    // Staging is refilled with the idle value before each frame so lanes
    // beyond the selected count always show the fill.
    wire stage_clear;

    assign stage_clear = (state == AOD_ST_IDLE) || frame_take;

    genvar g;
    generate
        for (g = 0; g < NUM_LANES; g = g + 1)
        begin : g_lane
            logic [31:0] stage_l;
            logic [31:0] stage_r;
            logic [31:0] out_l;
            logic [31:0] out_r;
            wire         hit;

            assign hit = fetch_done && (slot_lane == 2'(g));

            always_ff @(posedge i_core_clk)
            begin
                if (unit_rst || stage_clear)
                begin
                    stage_l <= zero_fill;
                    stage_r <= zero_fill;
                end
                else if (hit)
                begin
                    if (!slot_right)
                        stage_l <= sample;
                    if (slot_right || !stereo)
                        stage_r <= sample;
                end
            end

            // sample words and the idle fill both pass the inverter
            always_ff @(posedge i_core_clk)
            begin
                if (unit_rst)
                begin
                    out_l <= 32'h0;
                    out_r <= 32'h0;
                end
                else if (i_frame_req)
                begin
                    out_l <= (state == AOD_ST_FULL) ? stage_l : zero_fill;
                    out_r <= (state == AOD_ST_FULL) ? stage_r : zero_fill;
                end
            end

            assign o_left_data[g*32 +: 32]  = out_l;
            assign o_right_data[g*32 +: 32] = out_r;
        end
    endgenerate

    always_ff @(posedge i_core_clk)
    begin
        if (unit_rst)
            o_frame_filled <= 1'b0;
        else if (i_frame_req)
            o_frame_filled <= (state == AOD_ST_FULL);
    end

    //////////////////////////////////////////////////////////////////////////
    // Timestamp: survives the software reset to stay aligned with the core.

    logic [31:0] ts_count;
    logic [31:0] ts_latch;

    // cleared by chip or core reset
    always_ff @(posedge i_core_clk)
    begin
        if (ts_rst)
        begin
            ts_count <= 32'h0;
            ts_latch <= 32'h0;
        end
        else
        begin
            ts_count <= ts_count + 32'h1;
            if (buf_end)
                ts_latch <= ts_count;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Read back.

    wire [31:0] ctl_rd;
    wire [31:0] stat_rd;
    wire [31:0] rd_mux;

    // Acknowledge and reset bits read as zero.
    assign ctl_rd  = {21'h0, 2'h0, irq2_on, irq1_on, lanes, fmt,
                      invert, little, transmit_on};
    assign stat_rd = {29'h0, drained2, drained1, first_current};
    assign rd_mux  = (i_addr == AOD_OFS_CTL)    ? ctl_rd   :
                     (i_addr == AOD_OFS_STATUS) ? stat_rd  :
                     (i_addr == AOD_OFS_FIRST_BUFFER_BASE)  ? first_buffer_base    :
                     (i_addr == AOD_OFS_SECOND_BUFFER_BASE)  ? second_buffer_base    :
                     (i_addr == AOD_OFS_SIZE)   ? size     :
                     (i_addr == AOD_OFS_TSTAMP) ? ts_latch : 32'h0;

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n || !i_rd)
            o_rd_data <= 32'h0;
        else
            o_rd_data <= rd_mux;
    end

    //////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge i_core_clk);
    endclocking

    chk_reset_state: assert property (
        unit_rst |=> !transmit_on && first_current && state == AOD_ST_IDLE)
        else $error("unit reset did not restore start state");

    chk_addr_ascend: assert property (
        disable iff (unit_rst)
        fetch_done && !buf_end |=> offset == $past(offset) + $past(step))
        else $error("fetch address did not advance by one sample");

    chk_buf1_drain: assert property (
        disable iff (unit_rst)
        buf_end && first_current |=> drained1 && !first_current)
        else $error("buffer one drain not flagged or not switched");

    chk_buf2_drain: assert property (
        disable iff (unit_rst)
        buf_end && !first_current |=> drained2 && first_current)
        else $error("buffer two drain not flagged or not switched");

    chk_irq_level: assert property (
        disable iff (unit_rst)
        drained1 && irq1_on |-> o_irq)
        else $error("interrupt missing for drained buffer one");

    chk_ack_clear: assert property (
        disable iff (unit_rst)
        first_buffer_acknowledge && !(buf_end && first_current) |=> !drained1)
        else $error("acknowledge did not clear drained flag");

    chk_zero_invert: assert property (
        disable iff (unit_rst)
        invert && !is16 |-> zero_fill == AOD_MSB32)
        else $error("idle lane fill not inverted");

    chk_mono_dup: assert property (
        disable iff (unit_rst)
        frame_take && !stereo ##1 !$rose(soft_rst)
        |-> o_left_data == o_right_data)
        else $error("mono frame sides differ");

    chk_ts_keep: assert property (
        disable iff (ts_rst)
        soft_rst |=> ts_count == $past(ts_count) + 32'h1)
        else $error("timestamp disturbed by unit reset");

    cov_buf_switch: cover property (
        disable iff (unit_rst) buf_end ##[1:200] buf_end);
    cov_frame_out: cover property (
        disable iff (unit_rst) frame_take ##1 o_frame_filled);
    cov_soft_reset: cover property (transmit_on ##1 soft_rst);

endmodule

// ==== sim/aod_mem_model.sv ====
////////////////////////////////////////
// Purpose: Memory read port partner for the sample fetch DMA.
// Assumes: The byte at address a holds a[7:0] plus 8'h35.
// Notes:   Between answers the read data show the inverse of the last
//          word, so stale data cannot pass for a fresh answer.
////////////////////////////////////////
`timescale 1ns/1ns
module aod_mem_model
(
    // Clock and reset.
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_n,
    // Request from the DMA and answer speed.
    input  wire logic        i_req,
    input  wire logic [31:0] i_addr,
    input  wire logic        i_slow,
    // Answer.
    output logic             o_ack,
    output logic      [31:0] o_rdata
);
    logic [1:0]  wait_cnt;
    logic [31:0] last;
    logic [7:0]  b0;

    assign b0 = i_addr[7:0] + 8'h35;
    assign o_ack = i_req && (wait_cnt == (i_slow ? 2'h3 : 2'h0));
    // Byte k of the word is the byte at the word address plus k.
    assign o_rdata = o_ack ? {b0 + 8'h03, b0 + 8'h02, b0 + 8'h01, b0}
                           : ~last;

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n || !i_req || o_ack)
            wait_cnt <= 2'h0;
        else
            wait_cnt <= wait_cnt + 2'h1;
        if (!i_rst_n)
            last <= 32'h0;
        else if (o_ack)
            last <= o_rdata;
    end
endmodule

// ==== sim/tb.sv ====
////////////////////////////////////////
// Purpose: Self-checking bench for the sample fetch DMA.
// Assumes: Memory contents follow the partner model's byte pattern.
// Notes:   Expected samples are queued per fetch and popped per frame.
////////////////////////////////////////
`timescale 1ns/1ns
module tb
    import aod_pkg::*;
;
    localparam logic [31:0] B1 = 32'h0000_0100;
    localparam logic [31:0] B2 = 32'h0000_0400;
    localparam logic [31:0] SZ = 32'h0000_0040;
    logic         i_core_clk, i_rst_n, i_core_reset, i_wr, i_rd;
    logic         i_frame_req, slow, o_mem_req, i_mem_ack;
    logic         o_frame_filled, o_transmit_on, o_irq, little, inv, st;
    logic         is16;
    logic [7:0]   i_addr;
    logic [1:0]   fmt, lanes;
    logic [31:0]  i_wr_data, o_rd_data, o_mem_addr, i_mem_rdata;
    logic [31:0]  ea, rdv, ts, ctl;
    logic [127:0] o_left_data, o_right_data;
    logic [31:0]  q[$];
    int           bad_count, n_tests, cyc, cnt, sw, lim, need;

    aod_dma uut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
        .i_core_reset(i_core_reset), .i_addr(i_addr),
        .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd),
        .o_rd_data(o_rd_data), .o_mem_req(o_mem_req),
        .o_mem_addr(o_mem_addr), .i_mem_ack(i_mem_ack),
        .i_mem_rdata(i_mem_rdata), .i_frame_req(i_frame_req),
        .o_left_data(o_left_data), .o_right_data(o_right_data),
        .o_frame_filled(o_frame_filled), .o_transmit_on(o_transmit_on),
        .o_irq(o_irq));
    aod_mem_model mem (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
        .i_req(o_mem_req), .i_addr(o_mem_addr), .i_slow(slow),
        .o_ack(i_mem_ack), .o_rdata(i_mem_rdata));

    initial
    begin
        i_core_clk = 1'b0;
        forever #50 i_core_clk = ~i_core_clk;
    end

    task automatic test_done();
        $display("Checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, exp, input string m);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        i_addr <= a;
        i_wr_data <= d;
        i_wr <= 1'b1;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rdx(input logic [7:0] a);
        @(posedge i_core_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1;
        rdv = o_rd_data;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, string m);
        rdx(a);
        chk(rdv, e, m);
    endtask

    function automatic logic [31:0] smp(input logic [31:0] a);
        logic [7:0]  b0;
        logic [31:0] s;
        b0 = a[7:0] + 8'h35;
        if (is16)
            s = little ? {16'h0, b0 + 8'h01, b0} : {16'h0, b0, b0 + 8'h01};
        else if (little)
            s = {b0 + 8'h03, b0 + 8'h02, b0 + 8'h01, b0};
        else
            s = {b0, b0 + 8'h01, b0 + 8'h02, b0 + 8'h03};
        if (inv)
            s = s ^ (is16 ? AOD_MSB16 : AOD_MSB32);
        return s;
    endfunction

    // Fetch monitor: address order and the sample each fetch delivers.
    always @(posedge i_core_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            bad_count++;
            test_done();
        end
        if (i_rst_n && o_mem_req && i_mem_ack)
        begin
            chk(o_mem_addr, {ea[31:2], 2'b00}, "addr");
            q.push_back(smp(ea));
            ea = ea + (is16 ? AOD_STEP16 : AOD_STEP32);
            cnt++;
            if (cnt == lim)
            begin
                cnt = 0;
                sw++;
                ea = sw[0] ? B2 : B1;
            end
        end
    end

    task automatic staged();
        int k = 0;
        while (q.size() < need && k < 400)
        begin
            @(posedge i_core_clk);
            k++;
        end
    endtask

    task automatic frame(input logic filled);
        logic [31:0] l, r, fill;
        fill = inv ? (is16 ? AOD_MSB16 : AOD_MSB32) : 32'h0;
        if (filled)
            staged();
        @(posedge i_core_clk);
        i_frame_req <= 1'b1;
        @(posedge i_core_clk);
        i_frame_req <= 1'b0;
        @(posedge i_core_clk);
        #1;
        chk({31'h0, o_frame_filled}, {31'h0, filled}, "filled");
        for (int k = 0; k < 4; k++)
        begin
            l = fill;
            r = fill;
            if (filled && k <= int'(lanes))
            begin
                l = q.pop_front();
                r = st ? q.pop_front() : l;
            end
            chk(o_left_data[k*32+:32], l, "left");
            chk(o_right_data[k*32+:32], r, "right");
        end
    endtask

    task automatic run(input int i);
        fmt = i[1:0];
        lanes = i[1:0];
        little = i[0];
        inv = i[0] ^ i[1];
        slow = !i[0];
        st = fmt[0];
        is16 = fmt[1];
        need = (int'(lanes) + 1) * (st ? 2 : 1);
        ctl = 32'h0000_0081;
        ctl[AOD_CTL_FMT_LO+:2] = fmt;
        ctl[AOD_CTL_LANES_LO+:2] = lanes;
        ctl[AOD_CTL_LITTLE] = little;
        ctl[AOD_CTL_INVERT] = inv;
        ctl[AOD_CTL_IRQ2_ON] = i[1];
        wr(AOD_OFS_CTL, 32'h8000_0000);
        q.delete();
        ea = B1;
        cnt = 0;
        sw = 0;
        lim = st ? 128 : 64;
        wr(AOD_OFS_FIRST_BUFFER_BASE, B1);
        wr(AOD_OFS_SECOND_BUFFER_BASE, B2);
        wr(AOD_OFS_SIZE, SZ);
        rd(AOD_OFS_SIZE, SZ, "size");
        repeat (5) @(posedge i_core_clk);
        wr(AOD_OFS_CTL, ctl);
        if (slow)
            frame(1'b0);
        #1;
        chk({31'h0, o_transmit_on}, 32'h1, "txon");
        while (sw < 1)
            frame(1'b1);
        staged();
        rd(AOD_OFS_STATUS, 32'h2, "drain1");
        chk({31'h0, o_irq}, 32'h1, "irq1");
        wr(AOD_OFS_CTL, ctl | (32'h1 << AOD_CTL_FIRST_BUFFER_ACKNOWLEDGE));
        rd(AOD_OFS_STATUS, 32'h0, "first_buffer_acknowledge");
        chk({31'h0, o_irq}, 32'h0, "irq1 off");
        while (sw < 2)
            frame(1'b1);
        staged();
        rd(AOD_OFS_STATUS, 32'h5, "drain2");
        chk({31'h0, o_irq}, {31'h0, i[1]}, "irq2");
        wr(AOD_OFS_CTL, ctl | (32'h1 << AOD_CTL_ACK2));
        rd(AOD_OFS_STATUS, 32'h1, "ack2");
    endtask

    initial
    begin
        {i_rst_n, i_core_reset, i_wr, i_rd, i_frame_req, slow} = 6'h0;
        {little, inv, st, is16, fmt, lanes} = 8'h0;
        i_addr = 8'h0;
        i_wr_data = 32'h0;
        repeat (8) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        rd(AOD_OFS_CTL, 32'h0, "ctl rst");
        rd(AOD_OFS_STATUS, 32'h1, "st rst");
        for (int k = 0; k < 3; k++)
            rd(AOD_OFS_FIRST_BUFFER_BASE + 8'(4 * k), 32'h0, "buf rst");
        rd(8'h20, 32'h0, "unmapped");
        for (int i = 0; i < 4; i++)
            run(i);
        rdx(AOD_OFS_TSTAMP);
        chk({31'h0, rdv === 32'h0}, 32'h0, "tstamp");
        ts = rdv;
        wr(AOD_OFS_CTL, 32'h8000_0000);
        rd(AOD_OFS_TSTAMP, ts, "ts soft");
        rd(AOD_OFS_CTL, 32'h0, "ctl soft");
        rd(AOD_OFS_STATUS, 32'h1, "st soft");
        rd(AOD_OFS_FIRST_BUFFER_BASE, 32'h0, "base soft");
        wr(AOD_OFS_FIRST_BUFFER_BASE, B2);
        @(posedge i_core_clk);
        i_core_reset <= 1'b1;
        @(posedge i_core_clk);
        i_core_reset <= 1'b0;
        rd(AOD_OFS_FIRST_BUFFER_BASE, B2, "core rst");
        rd(AOD_OFS_TSTAMP, 32'h0, "ts core");
        test_done();
    end
endmodule
